// [include/bpt_pkg.sv]
// constants and types for the buck phase and tracking control block
package bpt_pkg;
  localparam int NUM_CH_DEF = 3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CH0 = 8'h00;
  localparam logic [7:0] CH_STRIDE = 8'h04;
  localparam logic [7:0] OFS_SETPOINT = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int CH_ILIM_LSB = 0;
  localparam int CH_PHASE_LSB = 2;
  localparam int CH_EN_BIT = 8;
  localparam int SP_R1_RUN_LSB = 0;
  localparam int SP_R1_STBY_LSB = 8;
  localparam int SP_R2_RUN_LSB = 16;
  localparam int SP_R2_STBY_LSB = 24;
  localparam int CTRL_TRK_BIT = 0;
  localparam int CTRL_STBY_BIT = 1;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_TRKSEL_BIT = 2;
  localparam int ST_DVS_BIT = 3;
  localparam int ST_HIZ_BIT = 4;
  localparam int ST_PD_LSB = 5;
  localparam int ST_CFG_LSB = 8;
  localparam int ST_CFGRSV_BIT = 10;
  localparam int ST_LOWR1_BIT = 11;
  localparam int ST_EN_LSB = 12;
  localparam int ST_DONE_BIT = 15;
  localparam logic [1:0] ILIM_RESET = 2'h0;
  localparam logic [2:0] PHASE_RESET = 3'h7;
  localparam logic [2:0] PHASE_ZERO_CODE = 3'h7;
  localparam logic [8:0] PHASE_STEP_DEG = 9'h02d;
  localparam logic [7:0] SP_R1_RESET = 8'h40;
  localparam logic [7:0] SP_R2_RESET = 8'h20;
  localparam logic [7:0] SP_R1_MIN = 8'h40;
  localparam logic [12:0] ILIM_MA_0 = 13'h0834;
  localparam logic [12:0] ILIM_MA_1 = 13'h0a28;
  localparam logic [12:0] ILIM_MA_2 = 13'h0bb8;
  localparam logic [12:0] ILIM_MA_3 = 13'h1194;
  localparam logic [10:0] IND_NH_0 = 11'h3e8;
  localparam logic [10:0] IND_NH_1 = 11'h1d6;
  localparam logic [10:0] IND_NH_2 = 11'h5dc;
  localparam logic [1:0] IND_RSVD = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_DUAL = 2'h1;
  localparam logic [1:0] CFG_RSVD = 2'h2;
  localparam logic [1:0] CFG_TRIPLE = 2'h3;
  typedef enum logic [1:0] {TRK_IDLE, TRK_RAMP, TRK_TRACK, TRK_FOLLOW} bpt_trk_state_type;
endpackage

// [logic/bpt_pin_sync.sv]
// three-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module bpt_pin_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic syncOut
);
  logic [2:0] stage;
  logic next_syncOut;
  // the output moves only once the second and third stages agree
  always_comb begin
    next_syncOut = syncOut;
    if (stage[1] == stage[2]) begin
      next_syncOut = stage[2];
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage <= 3'h0;
      syncOut <= 1'b0;
    end else begin
      stage <= {stage[1:0], pinIn};
      syncOut <= next_syncOut;
    end
  end
endmodule
`default_nettype wire

// [logic/bpt_chan_decode.sv]
// per-channel decode of current limit, phase shift and inductor fields
`timescale 1ns/1ps
`default_nettype none
module bpt_chan_decode
  import bpt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] ilimSel,
  input wire logic [2:0] phaseSel,
  input wire logic [1:0] inductorSel,
  output logic [12:0] limitMa,
  output logic [8:0] phaseDeg,
  output logic [10:0] inductorNh,
  output logic inductorReserved
);
  logic [12:0] next_limitMa;
  logic [8:0] next_phaseDeg;
  logic [10:0] next_inductorNh;
  always_comb begin
    case (ilimSel)
      2'h0: next_limitMa = ILIM_MA_0;
      2'h1: next_limitMa = ILIM_MA_1;
      2'h2: next_limitMa = ILIM_MA_2;
      default: next_limitMa = ILIM_MA_3;
    endcase
    // code n stands for (n+1) steps, the all-ones code for none
    if (phaseSel == PHASE_ZERO_CODE) begin
      next_phaseDeg = 9'h000;
    end else begin
      next_phaseDeg = 9'(PHASE_STEP_DEG * ({6'h00, phaseSel} + 9'h001));
    end
    case (inductorSel)
      2'h0: next_inductorNh = IND_NH_0;
      2'h1: next_inductorNh = IND_NH_1;
      2'h2: next_inductorNh = IND_NH_2;
      default: next_inductorNh = 11'h000;
    endcase
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      limitMa <= ILIM_MA_0;
      phaseDeg <= 9'h000;
      inductorNh <= IND_NH_0;
      inductorReserved <= 1'b0;
    end else begin
      limitMa <= next_limitMa;
      phaseDeg <= next_phaseDeg;
      inductorNh <= next_inductorNh;
      inductorReserved <= (inductorSel == IND_RSVD);
    end
  end
endmodule
`default_nettype wire

// [logic/bpt_buck_ctrl.sv]
// register file, phase combining and rail-two tracking sequencer
`timescale 1ns/1ps
`default_nettype none
module bpt_buck_ctrl #(
  parameter int NUM_CH = bpt_pkg::NUM_CH_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bpt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic systemOn,
  input wire logic [NUM_CH-1:0] seqEnable,
  input wire logic [2*NUM_CH-1:0] channelInductorSelOtp,
  input wire logic trackingDisableDischargeOtp,
  input wire logic [7:0] railTwoOtpSetpoint,
  input wire logic [1:0] phaseCombineConfigOtp,
  input wire logic railTwoRampDone,
  output logic [13*NUM_CH-1:0] limitMa,
  output logic [9*NUM_CH-1:0] phaseDeg,
  output logic [11*NUM_CH-1:0] inductorNh,
  output logic [NUM_CH-1:0] inductorReserved,
  output logic [NUM_CH-1:0] railEnable,
  output logic railTwoTrackSel,
  output logic railTwoDvsEnable,
  output logic [7:0] railTwoTarget,
  output logic [NUM_CH-1:0] railPulldown,
  output logic railTwoHighZ
);
  import bpt_pkg::*;

  // combining and tracking are wired for exactly three channels
  if (NUM_CH != 3) begin : g_chk
    $error("bpt_buck_ctrl supports only three channels");
  end

  logic [2*NUM_CH-1:0] ilim, next_ilim;
  logic [3*NUM_CH-1:0] phase, next_phase;
  logic [NUM_CH-1:0] chEn, next_chEn;
  logic [31:0] setpoint, next_setpoint;
  logic trkEn, next_trkEn, stbySel, next_stbySel;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic wrEn, rdSetup, mapped;
  logic [31:0] statusWord;
  logic rampDone;

  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  assign rdSetup = psel && !penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_STATUS);

  bpt_pin_sync u_done_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(railTwoRampDone),
    .syncOut(rampDone)
  );

  always_comb begin
    next_ilim = ilim;
    next_phase = phase;
    next_chEn = chEn;
    next_setpoint = setpoint;
    next_trkEn = trkEn;
    next_stbySel = stbySel;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (wrEn && paddr == OFS_CH0 + 8'(i * 4)) begin
        next_ilim[2*i+:2] = pwdata[CH_ILIM_LSB+:2];
        next_chEn[i] = pwdata[CH_EN_BIT];
        // phase is frozen outside the On state
        if (systemOn) begin
          next_phase[3*i+:3] = pwdata[CH_PHASE_LSB+:3];
        end
      end
      // a sequencer slot wins over a bus clear in the same cycle
      if (seqEnable[i]) begin
        next_chEn[i] = 1'b1;
      end
    end
    if (wrEn && paddr == OFS_SETPOINT) begin
      next_setpoint = pwdata;
    end
    if (wrEn && paddr == OFS_CTRL) begin
      next_trkEn = pwdata[CTRL_TRK_BIT];
      next_stbySel = pwdata[CTRL_STBY_BIT];
    end
    if (rdSetup) begin
      next_pslverr = !mapped;
      next_prdata = 32'h0000_0000;
      for (int i = 0; i < NUM_CH; i++) begin
        if (paddr == OFS_CH0 + 8'(i * 4)) begin
          next_prdata[CH_ILIM_LSB+:2] = ilim[2*i+:2];
          next_prdata[CH_PHASE_LSB+:3] = phase[3*i+:3];
          next_prdata[CH_EN_BIT] = chEn[i];
        end
      end
      case (paddr)
        OFS_SETPOINT: next_prdata = setpoint;
        OFS_CTRL: next_prdata = {30'h0, stbySel, trkEn};
        OFS_STATUS: next_prdata = statusWord;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ilim <= {NUM_CH{ILIM_RESET}};
      phase <= {NUM_CH{PHASE_RESET}};
      chEn <= '0;
      setpoint <= {SP_R2_RESET, SP_R2_RESET, SP_R1_RESET, SP_R1_RESET};
      trkEn <= 1'b0;
      stbySel <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ilim <= next_ilim;
      phase <= next_phase;
      chEn <= next_chEn;
      setpoint <= next_setpoint;
      trkEn <= next_trkEn;
      stbySel <= next_stbySel;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // phase combining: followers take channel one's fields and enable
  logic [1:0] cfg;
  logic [NUM_CH-1:0] follower;
  logic [2*NUM_CH-1:0] effIlim;
  logic [3*NUM_CH-1:0] effPhase;
  assign cfg = phaseCombineConfigOtp;
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    if (i == 0) begin : g_lead
      assign follower[i] = 1'b0;
    end else if (i == 1) begin : g_second
      assign follower[i] = (cfg == CFG_DUAL) || (cfg == CFG_TRIPLE);
    end else begin : g_third
      assign follower[i] = (cfg == CFG_TRIPLE);
    end
    assign effIlim[2*i+:2] = follower[i] ? ilim[1:0] : ilim[2*i+:2];
    assign effPhase[3*i+:3] = follower[i] ? phase[2:0] : phase[3*i+:3];
    assign railEnable[i] = follower[i] ? chEn[0] : chEn[i];
    bpt_chan_decode u_dec (
      .core_clk(core_clk),
      .rst(rst),
      .ilimSel(effIlim[2*i+:2]),
      .phaseSel(effPhase[3*i+:3]),
      .inductorSel(channelInductorSelOtp[2*i+:2]),
      .limitMa(limitMa[13*i+:13]),
      .phaseDeg(phaseDeg[9*i+:9]),
      .inductorNh(inductorNh[11*i+:11]),
      .inductorReserved(inductorReserved[i])
    );
  end

  // tracking sequencer for rail two; reserved or combined configs disable it
  bpt_trk_state_type trkState, next_trkState;
  logic trkActive, en1, en2, prevEn1, prevEn2, firstUp, next_firstUp;
  logic next_trkSel, next_dvs, next_hiz;
  logic [7:0] next_target;
  logic [NUM_CH-1:0] next_pd;
  assign trkActive = trkEn && (cfg == CFG_SINGLE);
  assign en1 = railEnable[0];
  assign en2 = railEnable[1];

  always_comb begin
    next_trkState = trkState;
    next_firstUp = firstUp;
    case (trkState)
      TRK_IDLE: begin
        if (trkActive && en2 && !prevEn2) begin
          // a shared slot, or rail one still off, tracks from the start
          if (!en1 || !prevEn1) begin
            next_trkState = TRK_TRACK;
          end else begin
            next_trkState = TRK_RAMP;
          end
        end
      end
      TRK_RAMP: begin
        if (!en2) begin
          next_trkState = TRK_IDLE;
        end else if (!en1) begin
          next_trkState = TRK_FOLLOW;
        end else if (rampDone) begin
          next_trkState = TRK_TRACK;
        end
      end
      TRK_TRACK: begin
        if (!en2) begin
          next_trkState = TRK_IDLE;
        end else if (!en1) begin
          next_trkState = TRK_FOLLOW;
        end
      end
      TRK_FOLLOW: begin
        if (!en2) begin
          next_trkState = TRK_IDLE;
        end else if (en1) begin
          next_trkState = TRK_TRACK;
        end
      end
      default: next_trkState = TRK_IDLE;
    endcase
    if (!trkActive) begin
      next_trkState = TRK_IDLE;
    end
    // the OTP aim must hold for the whole first ramp, not only its first cycle
    if (next_trkState == TRK_TRACK || (trkState == TRK_RAMP && next_trkState != TRK_RAMP)) begin
      next_firstUp = 1'b0;
    end
    next_trkSel = (next_trkState == TRK_TRACK) || (next_trkState == TRK_FOLLOW);
    next_dvs = !trkActive;
    next_target = stbySel ? setpoint[SP_R2_STBY_LSB+:8] : setpoint[SP_R2_RUN_LSB+:8];
    // first ramp after power-up aims at the OTP level unless rail two has already tracked; later ones at run or standby
    if (next_trkState == TRK_RAMP && firstUp) begin
      next_target = railTwoOtpSetpoint;
    end
    next_pd = '0;
    next_hiz = 1'b0;
    if (next_trkState == TRK_FOLLOW) begin
      next_pd[1:0] = 2'h3;
    end
    if (trkActive && !en2 && en1) begin
      next_pd[1] = trackingDisableDischargeOtp;
      next_hiz = !trackingDisableDischargeOtp;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trkState <= TRK_IDLE;
      firstUp <= 1'b1;
      prevEn1 <= 1'b0;
      prevEn2 <= 1'b0;
      railTwoTrackSel <= 1'b0;
      railTwoDvsEnable <= 1'b1;
      railTwoTarget <= SP_R2_RESET;
      railPulldown <= '0;
      railTwoHighZ <= 1'b0;
    end else begin
      trkState <= next_trkState;
      firstUp <= next_firstUp;
      prevEn1 <= en1;
      prevEn2 <= en2;
      railTwoTrackSel <= next_trkSel;
      railTwoDvsEnable <= next_dvs;
      railTwoTarget <= next_target;
      railPulldown <= next_pd;
      railTwoHighZ <= next_hiz;
    end
  end

  // rail one below 800 mV while tracking is only flagged; hardware cannot refuse it
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ST_STATE_LSB+:2] = trkState;
    statusWord[ST_TRKSEL_BIT] = railTwoTrackSel;
    statusWord[ST_DVS_BIT] = railTwoDvsEnable;
    statusWord[ST_HIZ_BIT] = railTwoHighZ;
    statusWord[ST_PD_LSB+:3] = railPulldown[2:0];
    statusWord[ST_CFG_LSB+:2] = cfg;
    statusWord[ST_CFGRSV_BIT] = (cfg == CFG_RSVD);
    statusWord[ST_LOWR1_BIT] = trkEn && (setpoint[SP_R1_RUN_LSB+:8] < SP_R1_MIN);
    statusWord[ST_EN_LSB+:3] = railEnable[2:0];
    statusWord[ST_DONE_BIT] = rampDone;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ilim_decode_a: assert property (effIlim[1:0] == 2'h3 |=> limitMa[12:0] == ILIM_MA_3)
    else $error("current limit code 3 not decoded to 4.5 A");
  phase_decode_a: assert property (effPhase[2:0] == 3'h6 |=> phaseDeg[8:0] == 9'h13b)
    else $error("phase code 6 not decoded to 315 degrees");
  phase_hold_a: assert property (!systemOn |=> phase == $past(phase))
    else $error("phase changed outside On state");
  phase_zero_a: assert property (effPhase[5:3] == 3'h7 |=> phaseDeg[17:9] == 9'h000)
    else $error("phase code 7 not decoded to zero");
  ind_decode_a: assert property (channelInductorSelOtp[1:0] == 2'h1
    |=> inductorNh[10:0] == IND_NH_1)
    else $error("inductor code 1 not decoded to 0.47 uH");
  track_sel_a: assert property (trkState == TRK_TRACK |-> railTwoTrackSel)
    else $error("tracking state without divided reference");
  dvs_off_a: assert property (trkActive ##1 trkActive |-> !railTwoDvsEnable)
    else $error("voltage scaling left on while tracking");
  same_slot_a: assert property (trkState == TRK_IDLE && trkActive && en1 && en2
    && !prevEn1 && !prevEn2 |=> trkState == TRK_TRACK)
    else $error("shared slot did not go straight to tracking");
  otp_ramp_a: assert property (trkState == TRK_RAMP && firstUp |-> railTwoTarget == railTwoOtpSetpoint)
    else $error("first ramp does not aim at OTP set-point");
  follow_pd_a: assert property (trkState == TRK_TRACK && trkActive && en2 && !en1
    |=> railPulldown[1:0] == 2'h3 ##1 (trkState == TRK_FOLLOW || !trkActive || !en2 || en1))
    else $error("rail one disable did not pull both rails down");
  reenable_a: assert property (trkState == TRK_FOLLOW && trkActive && en1 && en2
    |=> railTwoTrackSel && trkState == TRK_TRACK)
    else $error("rail two stopped tracking on rail one re-enable");
  hiz_a: assert property (trkActive && en1 && !en2 |=>
    railTwoHighZ == !$past(trackingDisableDischargeOtp)
    && railPulldown[1] == $past(trackingDisableDischargeOtp))
    else $error("rail two disable ignored discharge OTP bit");
  ramp_done_a: assert property (trkState == TRK_RAMP && rampDone && trkActive
    && en1 && en2 |=> trkState == TRK_TRACK)
    else $error("ramp completion did not start tracking");
  combine_a: assert property (cfg == CFG_TRIPLE |->
    effIlim[5:4] == ilim[1:0] && railEnable[2] == chEn[0])
    else $error("triple phase follower not slaved to channel one");
  cfg_rsvd_a: assert property (cfg == CFG_RSVD |-> !follower[1] && !follower[2])
    else $error("reserved combine code treated as combined");

  ramp_c: cover property (trkState == TRK_RAMP ##[1:50] trkState == TRK_TRACK);
  follow_c: cover property (trkState == TRK_FOLLOW ##[1:50] trkState == TRK_TRACK);
  hiz_c: cover property (railTwoHighZ);
  triple_c: cover property (cfg == CFG_TRIPLE && railEnable[2]);
endmodule
`default_nettype wire

// [test/tb.sv]
// self-checking testbench for the buck phase and tracking control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bpt_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic systemOn = 1'b0;
  logic [2:0] seqEnable = '0;
  logic [5:0] channelInductorSelOtp = '0;
  logic trackingDisableDischargeOtp = 1'b0;
  logic [7:0] railTwoOtpSetpoint = 8'h33;
  logic [1:0] phaseCombineConfigOtp = '0;
  logic railTwoRampDone = 1'b0;
  logic [38:0] limitMa;
  logic [26:0] phaseDeg;
  logic [32:0] inductorNh;
  logic [2:0] inductorReserved;
  logic [2:0] railEnable;
  logic railTwoTrackSel;
  logic railTwoDvsEnable;
  logic [7:0] railTwoTarget;
  logic [2:0] railPulldown;
  logic railTwoHighZ;
  int badCount = 0;
  int numChecks = 0;
  logic [31:0] rdv;
  logic errv;
  logic [12:0] ilimExp [4] = '{ILIM_MA_0, ILIM_MA_1, ILIM_MA_2, ILIM_MA_3};
  logic [10:0] indExp [4] = '{IND_NH_0, IND_NH_1, IND_NH_2, 11'h000};
  logic [2:0] cfgExp [4] = '{3'h1, 3'h3, 3'h1, 3'h7};

  always #2 core_clk = ~core_clk;

  bpt_buck_ctrl #(.NUM_CH(3)) i_bpt_buck_ctrl (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .systemOn, .seqEnable, .channelInductorSelOtp, .trackingDisableDischargeOtp,
    .railTwoOtpSetpoint, .phaseCombineConfigOtp, .railTwoRampDone, .limitMa, .phaseDeg,
    .inductorNh, .inductorReserved, .railEnable, .railTwoTrackSel, .railTwoDvsEnable,
    .railTwoTarget, .railPulldown, .railTwoHighZ
  );

  task automatic finish_test();
    if (badCount == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // entered just after a rising edge; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1) begin
      tick(1);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following setup never reassigns psel in this step
    tick(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, errv);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(1);
  endtask

  // rampDone crosses a synchroniser, so the wait is bounded rather than fixed
  task automatic ramp_wait();
    int n;
    n = 0;
    railTwoRampDone <= 1'b1;
    while (railTwoTrackSel !== 1'b1 && n < 20) begin
      n++;
      tick(1);
    end
    chk(32'(railTwoTrackSel), 32'h1);
    railTwoRampDone <= 1'b0;
    tick(8);
  endtask

  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0, rdv, errv);
    chk(rdv, 32'h0000001c);
    apb(1'b0, 8'h0c, 32'h0, rdv, errv);
    chk(rdv, 32'h20204040);
    chk(32'(phaseDeg), 32'h0);
    chk(32'(limitMa[12:0]), 32'(ILIM_MA_0));
  endtask

  task automatic t_ilim();
    for (int c = 0; c < 4; c++) begin
      wr(8'((c % 3) * 4), 32'h1c | 32'(c));
      tick(3);
      chk(32'(limitMa[13 * (c % 3) +: 13]), 32'(ilimExp[c]));
    end
  endtask

  task automatic t_phase();
    systemOn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(8'((c % 3) * 4), 32'(c << 2));
      tick(3);
      chk(32'(phaseDeg[9 * (c % 3) +: 9]), 32'((c == 7) ? 0 : (c + 1) * 45));
    end
    // phase is frozen outside On while the limit field still takes the write
    systemOn <= 1'b0;
    wr(8'h00, 32'h09);
    tick(3);
    chk(32'(phaseDeg[8:0]), 32'd315);
    chk(32'(limitMa[12:0]), 32'(ILIM_MA_1));
  endtask

  task automatic t_ind();
    for (int c = 0; c < 4; c++) begin
      channelInductorSelOtp <= {3{2'(c)}};
      tick(3);
      for (int ch = 0; ch < 3; ch++) begin
        chk(32'(inductorNh[11 * ch +: 11]), 32'(indExp[c]));
      end
      chk(32'(inductorReserved), (c == 3) ? 32'h7 : 32'h0);
    end
  endtask

  task automatic t_bus_err();
    apb(1'b0, 8'h18, 32'h0, rdv, errv);
    chk(32'(errv), 32'h1);
    apb(1'b0, 8'h02, 32'h0, rdv, errv);
    chk(32'(errv), 32'h1);
    apb(1'b0, 8'h10, 32'h0, rdv, errv);
    chk(32'(errv), 32'h0);
    chk(32'(pready), 32'h1);
  endtask

  task automatic t_combine();
    wr(8'h00, 32'h11c);
    for (int c = 0; c < 4; c++) begin
      phaseCombineConfigOtp <= 2'(c);
      tick(3);
      chk(32'(railEnable), 32'(cfgExp[c]));
    end
    phaseCombineConfigOtp <= 2'h0;
    wr(8'h00, 32'h1c);
  endtask

  task automatic t_track();
    wr(8'h0c, 32'h04024844);
    wr(8'h10, 32'h1);
    seqEnable <= 3'h3;
    tick(1);
    seqEnable <= 3'h0;
    tick(3);
    chk(32'(railTwoTrackSel), 32'h1);
    chk(32'(railTwoDvsEnable), 32'h0);
    apb(1'b0, 8'h14, 32'h0, rdv, errv);
    chk(rdv, 32'h00003006);
    wr(8'h00, 32'h1c);
    tick(3);
    chk(32'(railPulldown[1:0]), 32'h3);
    wr(8'h00, 32'h11c);
    tick(3);
    chk(32'(railPulldown), 32'h0);
    chk(32'(railTwoTrackSel), 32'h1);
    trackingDisableDischargeOtp <= 1'b0;
    wr(8'h04, 32'h1c);
    tick(3);
    chk(32'(railTwoHighZ), 32'h1);
    chk(32'(railPulldown[1]), 32'h0);
    trackingDisableDischargeOtp <= 1'b1;
    tick(3);
    chk(32'(railTwoHighZ), 32'h0);
    chk(32'(railPulldown[1]), 32'h1);
    wr(8'h10, 32'h3);
    wr(8'h04, 32'h11c);
    tick(3);
    chk(32'(railTwoTarget), 32'h04);
    chk(32'(railTwoTrackSel), 32'h0);
    ramp_wait();
  endtask

  task automatic t_later();
    do_reset();
    wr(8'h0c, 32'h00004040);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h11c);
    wr(8'h04, 32'h11c);
    tick(3);
    chk(32'(railTwoTarget), 32'h33);
    chk(32'(railTwoTrackSel), 32'h0);
    ramp_wait();
    wr(8'h04, 32'h1c);
    wr(8'h04, 32'h11c);
    tick(3);
    chk(32'(railTwoTarget), 32'h00);
    ramp_wait();
  endtask

  initial begin
    do_reset();
    t_reset();
    t_ilim();
    t_phase();
    t_ind();
    t_bus_err();
    t_combine();
    t_track();
    t_later();
    finish_test();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    tick(20000);
    badCount++;
    finish_test();
  end
endmodule
`default_nettype wire
